// file: loss_supervisor_regs.svh
// Register map, field layout and timing constants of the command loss supervisor.
// Summary of operation
// - Keypad supervision while run command from keypad.
// - Keypad action 0 does nothing.
// - Keypad action 1 raises keypad-loss warning output.
// - Keypad action 2 coasts, 3 ramps down.
// - Keypad ramp uses protective deceleration time.
// - Keypad supervision also covers jog key running.
// - Speed action 0 passes command straight through.
// - Speed action 1 blocks output, motor coasts.
// - Speed action 2 ramps down over protective time.
// - Speed action 3 holds ten-second input mean.
// - Speed action 4 holds ten-second output mean.
// - Speed action 5 runs at fallback preset.
// - Judgment time 0.1 to 120 s, default 1.0.
// - Criterion 1: below half minimum point.
// - Criterion 2: below minimum point.
// - Network source: no command for judgment time.
`ifndef LOSS_SUPERVISOR_REGS_SVH
`define LOSS_SUPERVISOR_REGS_SVH
`define REG_CTRL        12'h000
`define REG_JUDGE       12'h004
`define REG_PRESET      12'h008
`define REG_MINPT       12'h00C
`define REG_DECEL       12'h010
`define REG_STATUS      12'h014
`define REG_IRQ_STAT    12'h018
`define REG_IRQ_EN      12'h01C
`define REG_IRQ_CLR     12'h020
`define REG_FREQ        12'h024
`define CTRL_KPD_LSB    0
`define CTRL_SPD_LSB    2
`define CTRL_CRIT_LSB   5
`define CTRL_SRC_LSB    7
`define CTRL_CMD_KPD    9
`define CTRL_JOG_KEY    10
`define CTRL_RESET      32'h0000_0226
`define JUDGE_RESET     16'h000A
`define JUDGE_MIN       16'h0001
`define JUDGE_MAX       16'h04B0
`define PRESET_RESET    16'h0000
`define MINPT_RESET     16'h0000
`define DECEL_RESET     16'h0064
`define TICK_100MS      32'd10_000_000
`define AVG_SAMPLES     100
`define AVG_SHIFT       7
`endif

// file: loss_supervisor_pkg.sv
// Types shared by the command loss supervisor.
package loss_supervisor_pkg;
  typedef enum logic [1:0] {
    KPD_NONE = 2'b00,
    KPD_WARN = 2'b01,
    KPD_COAST = 2'b10,
    KPD_RAMP = 2'b11
  } keypad_loss_action_t;
  typedef enum logic [2:0] {
    SPD_NONE = 3'b000,
    SPD_COAST = 3'b001,
    SPD_RAMP = 3'b010,
    SPD_HOLD_IN = 3'b011,
    SPD_HOLD_OUT = 3'b100,
    SPD_PRESET = 3'b101
  } speed_loss_action_t;
  typedef enum logic [1:0] {
    SRC_ANALOG = 2'b00,
    SRC_OPTION = 2'b01,
    SRC_SERIAL = 2'b10
  } speed_source_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_COAST = 2'b01,
    ST_RAMP = 2'b10,
    ST_HOLD = 2'b11
  } drive_state_t;
endpackage : loss_supervisor_pkg

// file: command_loss_supervisor.sv
// Command loss supervisor with APB register slave and interrupt.
`timescale 1ns/1ns
`include "loss_supervisor_regs.svh"
module command_loss_supervisor #(
  parameter int unsigned TICK_CYCLES = `TICK_100MS,
  parameter int unsigned FW          = 16
) (
  input  wire logic          CLK,
  input  wire logic          RST_B,
  input  wire logic          PSEL,
  input  wire logic          PENABLE,
  input  wire logic          PWRITE,
  input  wire logic [11:0]   PADDR,
  input  wire logic [31:0]   PWDATA,
  output logic      [31:0]   PRDATA,
  output logic               PREADY,
  output logic               PSLVERR,
  input  wire logic          KEYPAD_LINK_OK,
  input  wire logic          RUNNING,
  input  wire logic          JOG_ACTIVE,
  input  wire logic [FW-1:0] ANALOG_IN,
  input  wire logic [FW-1:0] NET_CMD,
  input  wire logic          NET_CMD_VALID,
  input  wire logic [FW-1:0] OUT_FREQ,
  output logic      [FW-1:0] FREQ_CMD,
  output logic               OUTPUT_BLOCK,
  output logic               RAMP_STOP,
  output logic      [15:0]   RAMP_TIME,
  output logic               KEYPAD_LOSS_WARN,
  output logic               SPEED_LOSS_WARN,
  output logic               IRQ
);
  import loss_supervisor_pkg::*;

  logic [31:0]   ctrl_q;
  logic [15:0]   judge_q;
  logic [FW-1:0] preset_q;
  logic [FW-1:0] minpt_q;
  logic [15:0]   decel_q;
  logic [1:0]    irq_stat_q;
  logic [1:0]    irq_en_q;
  logic [1:0]    irq_clr;
  logic [1:0]    kpd_sync_q;
  logic [1:0]    run_sync_q;
  logic [1:0]    jog_sync_q;
  logic [FW-1:0] ain_s1_q;
  logic [FW-1:0] ain_q;
  logic          wr_en;
  logic          rd_en;
  logic          mapped;

  keypad_loss_action_t kpd_act;
  speed_loss_action_t  spd_act;
  speed_source_t       src;
  logic [1:0]          crit;
  assign kpd_act = keypad_loss_action_t'(ctrl_q[`CTRL_KPD_LSB +: 2]);
  assign spd_act = speed_loss_action_t'(ctrl_q[`CTRL_SPD_LSB +: 3]);
  assign crit    = ctrl_q[`CTRL_CRIT_LSB +: 2];
  assign src     = speed_source_t'(ctrl_q[`CTRL_SRC_LSB +: 2]);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; keypad link state arrives from another domain.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      kpd_sync_q <= 2'b11;
      run_sync_q <= 2'b00;
      jog_sync_q <= 2'b00;
      ain_s1_q   <= '0;
      ain_q      <= '0;
    end else begin
      kpd_sync_q <= {kpd_sync_q[0], KEYPAD_LINK_OK};
      run_sync_q <= {run_sync_q[0], RUNNING};
      jog_sync_q <= {jog_sync_q[0], JOG_ACTIVE};
      ain_s1_q   <= ANALOG_IN;
      ain_q      <= ain_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped address.
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;
  always_comb begin
    unique case (PADDR)
      `REG_CTRL, `REG_JUDGE, `REG_PRESET, `REG_MINPT, `REG_DECEL,
      `REG_STATUS, `REG_IRQ_STAT, `REG_IRQ_EN, `REG_IRQ_CLR,
      `REG_FREQ: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign irq_clr = (wr_en && PADDR == `REG_IRQ_CLR) ? PWDATA[1:0] : 2'b00;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_q   <= `CTRL_RESET;
      judge_q  <= `JUDGE_RESET;
      preset_q <= FW'(`PRESET_RESET);
      minpt_q  <= FW'(`MINPT_RESET);
      decel_q  <= `DECEL_RESET;
      irq_en_q <= 2'b00;
    end else if (wr_en) begin
      unique case (PADDR)
        `REG_CTRL: ctrl_q <= {21'h0, PWDATA[10:0]};
        `REG_JUDGE: begin
          // Out-of-range judgment times are clamped into 0.1 to 120 s.
          if (PWDATA[15:0] < `JUDGE_MIN) judge_q <= `JUDGE_MIN;
          else if (PWDATA[15:0] > `JUDGE_MAX) judge_q <= `JUDGE_MAX;
          else judge_q <= PWDATA[15:0];
        end
        `REG_PRESET: preset_q <= PWDATA[FW-1:0];
        `REG_MINPT: minpt_q <= PWDATA[FW-1:0];
        `REG_DECEL: decel_q <= PWDATA[15:0];
        `REG_IRQ_EN: irq_en_q <= PWDATA[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 100 ms tick divider.
  logic [31:0] div_q;
  logic        tick;
  assign tick = (div_q == TICK_CYCLES - 1);
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) div_q <= '0;
    else if (tick) div_q <= '0;
    else div_q <= div_q + 32'd1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed loss detection.
  logic          spd_bad;
  logic [15:0]   spd_cnt_q;
  logic          spd_lost_q;
  logic [FW-1:0] net_last_q;
  always_comb begin
    if (src == SRC_ANALOG) begin
      if (crit == 2'd1) spd_bad = ain_q < (minpt_q >> 1);
      else if (crit == 2'd2) spd_bad = ain_q < minpt_q;
      else spd_bad = 1'b0;
    end else begin
      spd_bad = !NET_CMD_VALID;
    end
  end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      spd_cnt_q  <= '0;
      spd_lost_q <= 1'b0;
    end else if (!spd_bad) begin
      // A valid command at any time restarts the judgment count.
      spd_cnt_q  <= '0;
      spd_lost_q <= 1'b0;
    end else if (tick && !spd_lost_q) begin
      spd_cnt_q <= spd_cnt_q + 16'd1;
      if (spd_cnt_q + 16'd1 >= judge_q) spd_lost_q <= 1'b1;
    end
  end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) net_last_q <= '0;
    else if (NET_CMD_VALID) net_last_q <= NET_CMD;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ten-second block means of input and output, one sample per tick while the command is good.
  logic [FW-1:0] cmd_in;
  logic [FW+6:0] sum_in_q;
  logic [FW+6:0] sum_out_q;
  logic [6:0]    nsamp_q;
  logic [FW-1:0] mean_in_q;
  logic [FW-1:0] mean_out_q;
  assign cmd_in = (src == SRC_ANALOG) ? ain_q : net_last_q;
  // A block mean over each 10 s window trades accuracy for no sample memory.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sum_in_q   <= '0;
      sum_out_q  <= '0;
      nsamp_q    <= '0;
      mean_in_q  <= '0;
      mean_out_q <= '0;
    end else if (tick && !spd_bad) begin
      if (nsamp_q == 7'(`AVG_SAMPLES - 1)) begin
        mean_in_q  <= FW'((sum_in_q + (FW+7)'(cmd_in)) / `AVG_SAMPLES);
        mean_out_q <= FW'((sum_out_q + (FW+7)'(OUT_FREQ)) / `AVG_SAMPLES);
        sum_in_q   <= '0;
        sum_out_q  <= '0;
        nsamp_q    <= '0;
      end else begin
        sum_in_q  <= sum_in_q + (FW+7)'(cmd_in);
        sum_out_q <= sum_out_q + (FW+7)'(OUT_FREQ);
        nsamp_q   <= nsamp_q + 7'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Keypad loss: judged only while running under keypad or jog key.
  logic kpd_lost;
  assign kpd_lost = !kpd_sync_q[1] && run_sync_q[1]
                    && (ctrl_q[`CTRL_CMD_KPD]
                        || (jog_sync_q[1] && ctrl_q[`CTRL_JOG_KEY]));

  ////////////////////////////////////////////////////////////////////////////
  // Action resolution; coast dominates ramp which dominates hold.
  drive_state_t  state_d;
  logic [FW-1:0] freq_d;
  always_comb begin
    state_d = ST_RUN;
    freq_d  = cmd_in;
    if (spd_lost_q) begin
      unique case (spd_act)
        SPD_COAST: state_d = ST_COAST;
        SPD_RAMP: state_d = ST_RAMP;
        SPD_HOLD_IN: freq_d = mean_in_q;
        SPD_HOLD_OUT: freq_d = mean_out_q;
        SPD_PRESET: freq_d = preset_q;
        default: ;
      endcase
    end
    if (kpd_lost) begin
      unique case (kpd_act)
        KPD_COAST: state_d = ST_COAST;
        KPD_RAMP: if (state_d != ST_COAST) state_d = ST_RAMP;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      FREQ_CMD         <= '0;
      OUTPUT_BLOCK     <= 1'b0;
      RAMP_STOP        <= 1'b0;
      RAMP_TIME        <= `DECEL_RESET;
      KEYPAD_LOSS_WARN <= 1'b0;
      SPEED_LOSS_WARN  <= 1'b0;
    end else begin
      FREQ_CMD         <= freq_d;
      OUTPUT_BLOCK     <= state_d == ST_COAST;
      RAMP_STOP        <= state_d == ST_RAMP;
      RAMP_TIME        <= decel_q;
      KEYPAD_LOSS_WARN <= kpd_lost && kpd_act == KPD_WARN;
      SPEED_LOSS_WARN  <= spd_lost_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky events; a new event in the clearing cycle survives the clear.
  logic [1:0] ev;
  assign ev = {spd_lost_q, kpd_lost && kpd_act != KPD_NONE};
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) irq_stat_q <= 2'b00;
    else irq_stat_q <= (irq_stat_q & ~irq_clr) | ev;
  end
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) IRQ <= 1'b0;
    else IRQ <= |(irq_stat_q & irq_en_q);
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      PRDATA  <= '0;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped;
      PRDATA  <= '0;
      if (PSEL && !PENABLE && !PWRITE) begin
        unique case (PADDR)
          `REG_CTRL: PRDATA <= ctrl_q;
          `REG_JUDGE: PRDATA <= {16'h0, judge_q};
          `REG_PRESET: PRDATA <= 32'(preset_q);
          `REG_MINPT: PRDATA <= 32'(minpt_q);
          `REG_DECEL: PRDATA <= {16'h0, decel_q};
          `REG_STATUS: PRDATA <= {28'h0, state_d, spd_lost_q, kpd_lost};
          `REG_IRQ_STAT: PRDATA <= {30'h0, irq_stat_q};
          `REG_IRQ_EN: PRDATA <= {30'h0, irq_en_q};
          `REG_FREQ: PRDATA <= 32'(freq_d);
          default: PRDATA <= '0;
        endcase
      end
    end
  end
  logic unused_rd;
  assign unused_rd = rd_en;
endmodule : command_loss_supervisor

// file: loss_supervisor_props.sv
// Concurrent checks on the supervisor's bus and protective outputs.
`timescale 1ns/1ns
module loss_supervisor_props (
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        KEYPAD_LINK_OK,
  input wire logic        OUTPUT_BLOCK,
  input wire logic        RAMP_STOP,
  input wire logic [15:0] RAMP_TIME,
  input wire logic        KEYPAD_LOSS_WARN,
  input wire logic        SPEED_LOSS_WARN
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  ////////////////////////////////////////////////////////////////////
  a_ready_access: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no zero-wait answer");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_ready_in_access: assert property (PREADY |-> PSEL && PENABLE)
    else $error("ready outside access");
  a_err_is_ready: assert property (PSLVERR |-> PREADY && PRDATA == 0)
    else $error("error without ready or with data");
  a_coast_wins: assert property (OUTPUT_BLOCK |-> !RAMP_STOP)
    else $error("coast and ramp together");
  a_link_good_quiet: assert property (KEYPAD_LINK_OK [*5] |->
    !KEYPAD_LOSS_WARN) else $error("keypad warning with good link");
  a_ramp_time_held: assert property (!(PSEL && PENABLE && PWRITE)
    ##1 !(PSEL && PENABLE && PWRITE) |=> $stable(RAMP_TIME))
    else $error("ramp time moved without a write");
  a_block_cause: assert property ($rose(OUTPUT_BLOCK) |->
    SPEED_LOSS_WARN || !$past(KEYPAD_LINK_OK, 3))
    else $error("output blocked with no loss");
endmodule : loss_supervisor_props

// file: loss_source_model.sv
// Keypad link and speed-command sources facing the supervisor.
`timescale 1ns/1ns
module loss_source_model (
  input  wire logic        clk,
  input  wire logic        link_cut,
  input  wire logic        net_on,
  input  wire logic [15:0] level,
  output logic             link_ok,
  output logic      [15:0] analog,
  output logic      [15:0] net_cmd,
  output logic             net_valid
);
  always_ff @(posedge clk) begin
    link_ok   <= !link_cut;
    analog    <= level;
    net_valid <= net_on;
    // A silent link shows the inverse, so a stale command cannot pass.
    net_cmd   <= net_on ? level : ~level;
  end
endmodule : loss_source_model

// file: testbench.sv
// Self-checking bench for the command loss supervisor.
`timescale 1ns/1ns
`include "loss_supervisor_regs.svh"
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("Error %0t: got %h expected %h", $time, g, e); \
  end \
end
module testbench;
  logic        CLK, RST_B, PSEL, PENABLE, PWRITE, RUNNING, JOG_ACTIVE;
  logic        PREADY, PSLVERR, KEYPAD_LINK_OK, NET_CMD_VALID, IRQ;
  logic        OUTPUT_BLOCK, RAMP_STOP, KEYPAD_LOSS_WARN, SPEED_LOSS_WARN;
  logic        link_cut, net_on, rerr;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdat;
  logic [15:0] ANALOG_IN, NET_CMD, FREQ_CMD, RAMP_TIME, level;
  int          miscompares, n_tests, cyc, k, a;
  command_loss_supervisor #(.TICK_CYCLES(10)) dut (.CLK(CLK),
    .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .KEYPAD_LINK_OK(KEYPAD_LINK_OK), .RUNNING(RUNNING),
    .JOG_ACTIVE(JOG_ACTIVE), .ANALOG_IN(ANALOG_IN), .NET_CMD(NET_CMD),
    .NET_CMD_VALID(NET_CMD_VALID), .OUT_FREQ(16'h0100),
    .FREQ_CMD(FREQ_CMD), .OUTPUT_BLOCK(OUTPUT_BLOCK),
    .RAMP_STOP(RAMP_STOP), .RAMP_TIME(RAMP_TIME),
    .KEYPAD_LOSS_WARN(KEYPAD_LOSS_WARN),
    .SPEED_LOSS_WARN(SPEED_LOSS_WARN), .IRQ(IRQ));
  loss_source_model partner (.clk(CLK), .link_cut(link_cut),
    .net_on(net_on), .level(level), .link_ok(KEYPAD_LINK_OK),
    .analog(ANALOG_IN), .net_cmd(NET_CMD), .net_valid(NET_CMD_VALID));
  always #5 CLK = ~CLK;
  ////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [11:0] ad,
                      input logic [31:0] d);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= ad;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : xfer
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d);
  endtask : wr
  task automatic rd(input logic [11:0] ad, input logic [31:0] e,
                    input logic er);
    xfer(1'b0, ad, 32'h0);
    `CHK(rdat, e)
    `CHK(rerr, er)
  endtask : rd
  task automatic rst;
    RST_B      <= 1'b0;
    link_cut   <= 1'b0;
    net_on     <= 1'b1;
    RUNNING    <= 1'b1;
    JOG_ACTIVE <= 1'b0;
    level      <= 16'h0321;
    repeat (10) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
  endtask : rst
  task print_verdict;
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    CLK = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    rst;
    rd(`REG_CTRL, 32'h0000_0226, 1'b0);
    rd(`REG_JUDGE, 32'h0000_000A, 1'b0);
    rd(`REG_DECEL, 32'h0000_0064, 1'b0);
    rd(`REG_PRESET, 32'h0, 1'b0);
    wr(`REG_STATUS, 32'hFFFF_FFFF);
    rd(`REG_STATUS, 32'h0, 1'b0);
    rd(12'h028, 32'h0, 1'b1);
    wr(`REG_JUDGE, 32'h0);
    rd(`REG_JUDGE, 32'h1, 1'b0);
    wr(`REG_JUDGE, 32'hFFFF);
    rd(`REG_JUDGE, 32'h4B0, 1'b0);
    // Network source; three ticks must pass, so twelve cycles cannot trip.
    wr(`REG_JUDGE, 32'h3);
    wr(`REG_PRESET, 32'h1234);
    wr(`REG_IRQ_EN, 32'h3);
    wr(`REG_CTRL, 32'h94);
    net_on <= 1'b0;
    repeat (12) @(posedge CLK);
    net_on <= 1'b1;
    repeat (30) @(posedge CLK);
    net_on <= 1'b0;
    repeat (12) @(posedge CLK);
    `CHK(SPEED_LOSS_WARN, 1'b0)
    k = 0;
    while (SPEED_LOSS_WARN !== 1'b1 && k < 300) begin
      @(posedge CLK);
      k++;
    end
    `CHK(SPEED_LOSS_WARN, 1'b1)
    `CHK(FREQ_CMD, 16'h1234)
    repeat (2) @(posedge CLK);
    `CHK(IRQ, 1'b1)
    rd(`REG_IRQ_STAT, 32'h2, 1'b0);
    wr(`REG_IRQ_EN, 32'h0);
    repeat (2) @(posedge CLK);
    `CHK(IRQ, 1'b0)
    net_on <= 1'b1;
    repeat (20) @(posedge CLK);
    wr(`REG_IRQ_EN, 32'h3);
    repeat (2) @(posedge CLK);
    `CHK(IRQ, 1'b1)
    wr(`REG_IRQ_CLR, 32'h3);
    repeat (2) @(posedge CLK);
    `CHK(IRQ, 1'b0)
    for (a = 0; a < 3; a++) begin
      rst;
      wr(`REG_JUDGE, 32'h1);
      wr(`REG_CTRL, 32'h80 | (a << 2));
      if (a == 0) `CHK(FREQ_CMD, 16'h0321)
      net_on <= 1'b0;
      repeat (40) @(posedge CLK);
      `CHK(OUTPUT_BLOCK, a == 1)
      `CHK(RAMP_STOP, a == 2)
    end
    for (a = 3; a < 5; a++) begin
      rst;
      wr(`REG_JUDGE, 32'h1);
      wr(`REG_CTRL, 32'h80 | (a << 2));
      repeat (1100) @(posedge CLK);
      net_on <= 1'b0;
      repeat (40) @(posedge CLK);
      `CHK(FREQ_CMD, (a == 3) ? 16'h0321 : 16'h0100)
    end
    for (a = 1; a < 3; a++) begin
      rst;
      wr(`REG_MINPT, 32'h100);
      wr(`REG_JUDGE, 32'h1);
      wr(`REG_CTRL, 32'h4 | (a << 5));
      level <= 16'h00C0;
      repeat (40) @(posedge CLK);
      `CHK(OUTPUT_BLOCK, a == 2)
      level <= 16'h007F;
      repeat (40) @(posedge CLK);
      `CHK(OUTPUT_BLOCK, 1'b1)
    end
    for (a = 0; a < 4; a++) begin
      rst;
      wr(`REG_CTRL, ((a == 3) ? 32'h400 : 32'h600) | a);
      RUNNING    <= 1'b1;
      JOG_ACTIVE <= (a == 3);
      link_cut   <= 1'b1;
      repeat (10) @(posedge CLK);
      `CHK(KEYPAD_LOSS_WARN, a == 1)
      `CHK(OUTPUT_BLOCK, a == 2)
      `CHK(RAMP_STOP, a == 3)
    end
    `CHK(RAMP_TIME, 16'h0064)
    rst;
    wr(`REG_CTRL, 32'h2);
    link_cut <= 1'b1;
    repeat (10) @(posedge CLK);
    `CHK(OUTPUT_BLOCK, 1'b0)
    print_verdict;
  end
endmodule : testbench
bind command_loss_supervisor loss_supervisor_props props (.CLK(CLK),
  .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .KEYPAD_LINK_OK(KEYPAD_LINK_OK), .OUTPUT_BLOCK(OUTPUT_BLOCK),
  .RAMP_STOP(RAMP_STOP), .RAMP_TIME(RAMP_TIME),
  .KEYPAD_LOSS_WARN(KEYPAD_LOSS_WARN), .SPEED_LOSS_WARN(SPEED_LOSS_WARN));
